// ---- ierwp_pkg.sv ----
// Purpose: Shared constants and types for the serial EEPROM link, device end and master end.
// Assumes: 9-bit byte address, 16-byte pages, 20 MHz master clock.
// Notes: The SCL quarter count derives from the periods given here; the programming time is a plain count.
package ierwp_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 512;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
    // Bit count values inside one 9-clock byte slot
    localparam logic [3:0] CNT_ACK = 4'h8;
    localparam logic [3:0] CNT_DONE = 4'h9;
    // Synchroniser idle value: {scl, sda, wp, cs_high, cs_low}
    localparam logic [4:0] PIN_IDLE = 5'h18;
    // Internal programming time in link clock cycles (plain default)
    localparam int PROG_CYCLES_DEF = 2000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCL_PERIOD_NS = 2500;
    // Quarter of the serial clock period, rounded down
    localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
    typedef enum logic [1:0] {
        OP_WRITE,
        OP_RAND_READ,
        OP_CUR_READ
    } ierwp_op_e;
endpackage : ierwp_pkg

// ---- ierwp_link_if.sv ----
// Purpose: Two-wire link between the bus master and the EEPROM device end.
// Assumes: SCL driven by the master only; SDA is open drain with a pull-up.
// Notes: A driver pulls low only while its enable is high and its output is low.
`timescale 1ns/1ps
interface ierwp_link_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda;

    // Wired-AND with pull-up
    assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

    modport host (
        output scl,
        output sda_host_o,
        output sda_host_oe,
        input sda
    );
    modport dev (
        input scl,
        input sda,
        output sda_dev_o,
        output sda_dev_oe
    );
endinterface : ierwp_link_if

// ---- ierwp_eeprom_dev.sv ----
// Purpose: EEPROM device end: addressing, acknowledge, write protect, page write, reads.
// Assumes: LINK_CLK oversamples SCL and SDA; RST is synchronous to LINK_CLK.
// Notes: Memory starts erased; page commit takes PROG_CYCLES link clock cycles.
`timescale 1ns/1ps
module ierwp_eeprom_dev #(
    parameter int PROG_CYCLES = ierwp_pkg::PROG_CYCLES_DEF
) (
    input wire logic LINK_CLK,
    input wire logic RST,
    ierwp_link_if.dev LINK,
    input wire logic WP,
    input wire logic CHIP_SELECT_PIN_LOW,
    input wire logic CHIP_SELECT_PIN_HIGH,
    output logic BUSY
);
    import ierwp_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV_ADDR,
        ST_WORD_ADDR,
        ST_WR_DATA,
        ST_RD_DATA,
        ST_PROG
    } ierwp_dev_st_e;

    localparam int PCW = $clog2(PROG_CYCLES + 1);
    localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES - 1);
    localparam logic [PCW-1:0] PROG_PAGE_END = PCW'(PAGE_BYTES);

    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic scl_q_reg;
    logic sda_q_reg;
    ierwp_dev_st_e state_reg;
    logic [3:0] cnt_reg;
    logic [DATA_W-1:0] rx_reg;
    logic [DATA_W-1:0] tx_reg;
    logic oe_reg;
    logic [ADDR_W-1:0] ptr_reg;
    logic upper_memory_address_bit_reg;
    logic rd_reg;
    logic mack_reg;
    logic wp_lat_reg;
    logic refused_reg;
    logic [PAGE_BYTES-1:0] pvalid_reg;
    logic [PCW-1:0] prog_cnt_reg;
    // erased at start
    // Set by the declaration only, so the write process stays the array's sole writer
    logic [DATA_W-1:0] mem [0:MEM_DEPTH-1] = '{default: ERASED_BYTE};
    logic [DATA_W-1:0] pbuf [0:PAGE_BYTES-1];

    logic scl;
    logic sda;
    logic wp_s;
    logic start_det;
    logic stop_det;
    logic rise;
    logic fall;
    logic addr_match;
    logic wr_accept;
    logic prog_done;
    logic commit_en;
    logic [PAGE_W-1:0] commit_idx;
    logic [DATA_W-1:0] rd_byte;

    assign scl = pin_s2_reg[4];
    assign sda = pin_s2_reg[3];
    assign wp_s = pin_s2_reg[2];
    // Edge and condition detection only on the second synchroniser stage
    assign start_det = scl & scl_q_reg & sda_q_reg & ~sda;
    assign stop_det = scl & scl_q_reg & ~sda_q_reg & sda;
    assign rise = scl & ~scl_q_reg;
    assign fall = ~scl & scl_q_reg;
    assign addr_match = (rx_reg[7:4] == DEV_TYPE_CODE) && (rx_reg[3] == pin_s2_reg[1])
        && (rx_reg[2] == pin_s2_reg[0]);
    assign wr_accept = (state_reg == ST_WR_DATA) && fall && (cnt_reg == CNT_ACK)
        && !wp_lat_reg && !refused_reg;
    assign prog_done = (state_reg == ST_PROG) && (prog_cnt_reg == PROG_LAST);
    assign commit_idx = prog_cnt_reg[PAGE_W-1:0];
    assign commit_en = (state_reg == ST_PROG) && (prog_cnt_reg < PROG_PAGE_END)
        && pvalid_reg[commit_idx];
    assign rd_byte = mem[ptr_reg];

    assign LINK.sda_dev_o = 1'b0;
    assign LINK.sda_dev_oe = oe_reg;
    assign BUSY = (state_reg == ST_PROG);

    // Pins come from another domain; two stages before any use
    always_ff @(posedge LINK_CLK) begin
        if (RST) begin
            pin_s1_reg <= PIN_IDLE;
            pin_s2_reg <= PIN_IDLE;
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            pin_s1_reg <= {LINK.scl, LINK.sda, WP, CHIP_SELECT_PIN_HIGH, CHIP_SELECT_PIN_LOW};
            pin_s2_reg <= pin_s1_reg;
            scl_q_reg <= pin_s2_reg[4];
            sda_q_reg <= pin_s2_reg[3];
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            oe_reg <= 1'b0;
            ptr_reg <= 9'h000;
            upper_memory_address_bit_reg <= 1'b0;
            rd_reg <= 1'b0;
            mack_reg <= 1'b0;
            wp_lat_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else if (state_reg == ST_PROG) begin
            oe_reg <= 1'b0;
            if (prog_done) begin
                state_reg <= ST_IDLE;
            end
        end else if (start_det) begin
            state_reg <= ST_DEV_ADDR;
            cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else if (stop_det) begin
            oe_reg <= 1'b0;
            state_reg <= (|pvalid_reg && !refused_reg) ? ST_PROG : ST_IDLE;
        end else if (state_reg != ST_IDLE) begin
            if (rise) begin
                if (cnt_reg < CNT_ACK) begin
                    rx_reg <= {rx_reg[6:0], sda};
                end else begin
                    mack_reg <= ~sda;
                end
                cnt_reg <= cnt_reg + 4'h1;
            end else if (fall && cnt_reg == CNT_ACK) begin
                unique case (state_reg)
                    ST_DEV_ADDR: begin
                        if (addr_match) begin
                            oe_reg <= 1'b1;
                            upper_memory_address_bit_reg <= rx_reg[1];
                            rd_reg <= rx_reg[0];
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_WORD_ADDR: begin
                        oe_reg <= 1'b1;
                    end
                    ST_WR_DATA: begin
                        if (wr_accept) begin
                            oe_reg <= 1'b1;
                            ptr_reg <= {ptr_reg[ADDR_W-1:PAGE_W], ptr_reg[PAGE_W-1:0] + 4'h1};
                        end else begin
                            refused_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_RD_DATA: begin
                        oe_reg <= 1'b0;
                        ptr_reg <= ptr_reg + 9'h001;
                    end
                    default: begin
                        oe_reg <= 1'b0;
                    end
                endcase
            end else if (fall && cnt_reg == CNT_DONE) begin
                cnt_reg <= 4'h0;
                oe_reg <= 1'b0;
                unique case (state_reg)
                    ST_DEV_ADDR: begin
                        if (rd_reg) begin
                            state_reg <= ST_RD_DATA;
                            oe_reg <= ~rd_byte[7];
                            tx_reg <= {rd_byte[6:0], 1'b0};
                        end else begin
                            state_reg <= ST_WORD_ADDR;
                        end
                    end
                    ST_WORD_ADDR: begin
                        ptr_reg <= {upper_memory_address_bit_reg, rx_reg};
                        wp_lat_reg <= wp_s;
                        state_reg <= ST_WR_DATA;
                    end
                    ST_RD_DATA: begin
                        if (mack_reg) begin
                            oe_reg <= ~rd_byte[7];
                            tx_reg <= {rd_byte[6:0], 1'b0};
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= state_reg;
                    end
                endcase
            end else if (fall && state_reg == ST_RD_DATA && cnt_reg != 4'h0) begin
                oe_reg <= ~tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    // Page buffer; a new START abandons a page not yet closed by STOP
    always_ff @(posedge LINK_CLK) begin
        if (RST) begin
            pvalid_reg <= '0;
        end else if (prog_done || (start_det && state_reg != ST_PROG)) begin
            pvalid_reg <= '0;
        end else if (wr_accept) begin
            pvalid_reg[ptr_reg[PAGE_W-1:0]] <= 1'b1;
            pbuf[ptr_reg[PAGE_W-1:0]] <= rx_reg;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (RST || state_reg != ST_PROG) begin
            prog_cnt_reg <= '0;
        end else begin
            prog_cnt_reg <= prog_cnt_reg + PCW'(1);
        end
    end

    // One byte per cycle at the start of programming keeps a single write port
    always_ff @(posedge LINK_CLK) begin
        if (commit_en) begin
            mem[{ptr_reg[ADDR_W-1:PAGE_W], commit_idx}] <= pbuf[commit_idx];
        end
    end
endmodule : ierwp_eeprom_dev

// ---- ierwp_bus_master.sv ----
// Purpose: Master end: makes SCL, runs byte write, random read and current read.
// Assumes: Device end on the same link; CLK at 20 MHz.
// Notes: One command at a time; a missing acknowledge aborts with STOP.
`timescale 1ns/1ps
module ierwp_bus_master #(
    parameter int QUARTER_CYC = ierwp_pkg::SCL_QUARTER_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    ierwp_link_if.host LINK,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire ierwp_pkg::ierwp_op_e CMD_OP,
    input wire logic [1:0] CMD_CS,
    input wire logic [ierwp_pkg::ADDR_W-1:0] CMD_ADDR,
    input wire logic [ierwp_pkg::DATA_W-1:0] CMD_WDATA,
    input wire logic [4:0] CMD_LEN,
    output logic RD_VALID,
    output logic [ierwp_pkg::DATA_W-1:0] RD_DATA,
    output logic DONE,
    output logic NACK
);
    import ierwp_pkg::*;

    typedef enum logic [3:0] {
        H_IDLE, H_START, H_DEVW, H_WADDR, H_WDATA, H_RESTART, H_DEVR, H_RDATA, H_STOP
    } ierwp_hst_e;

    localparam logic [7:0] QLAST = 8'(QUARTER_CYC - 1);

    ierwp_hst_e st_reg;
    ierwp_op_e op_reg;
    logic [1:0] cs_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [4:0] left_reg;
    logic [7:0] div_reg;
    logic [1:0] ph_reg;
    logic [3:0] bit_reg;
    logic scl_reg;
    logic oe_reg;
    logic [DATA_W-1:0] tx_reg;
    logic [DATA_W-1:0] rx_reg;
    logic sda_s1_reg;
    logic sda_s2_reg;
    logic rd_valid_reg;
    logic [DATA_W-1:0] rd_data_reg;
    logic done_reg;
    logic nack_reg;
    logic tick;
    logic drive_low;
    logic [DATA_W-1:0] addr_byte;

    assign tick = (div_reg == QLAST);
    assign addr_byte = {DEV_TYPE_CODE, cs_reg, addr_reg[ADDR_W-1], 1'b0};
    assign CMD_READY = (st_reg == H_IDLE);
    assign RD_VALID = rd_valid_reg;
    assign RD_DATA = rd_data_reg;
    assign DONE = done_reg;
    assign NACK = nack_reg;
    assign LINK.scl = scl_reg;
    assign LINK.sda_host_o = 1'b0;
    assign LINK.sda_host_oe = oe_reg;

    always_comb begin
        unique case (st_reg)
            H_STOP: drive_low = 1'b1;
            H_IDLE, H_START, H_RESTART: drive_low = 1'b0;
            // acknowledge all but the last byte
            H_RDATA: drive_low = (bit_reg == CNT_ACK) && (left_reg != 5'h01);
            default: drive_low = (bit_reg != CNT_ACK) && !tx_reg[7];
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
        end else begin
            sda_s1_reg <= LINK.sda;
            sda_s2_reg <= sda_s1_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || st_reg == H_IDLE || tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_reg <= H_IDLE;
            op_reg <= OP_WRITE;
            cs_reg <= 2'h0;
            addr_reg <= 9'h000;
            wdata_reg <= 8'h00;
            left_reg <= 5'h00;
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            scl_reg <= 1'b1;
            oe_reg <= 1'b0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            rd_data_reg <= 8'h00;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else if (st_reg == H_IDLE) begin
            done_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            if (CMD_VALID) begin
                op_reg <= CMD_OP;
                cs_reg <= CMD_CS;
                addr_reg <= CMD_ADDR;
                wdata_reg <= CMD_WDATA;
                left_reg <= (CMD_LEN == 5'h00) ? 5'h01 : CMD_LEN;
                nack_reg <= 1'b0;
                ph_reg <= 2'h0;
                bit_reg <= 4'h0;
                st_reg <= H_START;
            end
        end else begin
            rd_valid_reg <= 1'b0;
            if (tick) begin
                ph_reg <= ph_reg + 2'h1;
                unique case (ph_reg)
                    2'h0: scl_reg <= 1'b0;
                    2'h1: oe_reg <= drive_low;
                    2'h2: scl_reg <= 1'b1;
                    default: begin
                        if (st_reg == H_START || st_reg == H_RESTART) begin
                            // START: SDA falls while SCL is high
                            oe_reg <= 1'b1;
                            st_reg <= H_DEVR;
                            tx_reg <= addr_byte | 8'h01;
                            if (st_reg == H_START && op_reg != OP_CUR_READ) begin
                                st_reg <= H_DEVW;
                                tx_reg <= addr_byte;
                            end
                        end else if (st_reg == H_STOP) begin
                            oe_reg <= 1'b0;
                            done_reg <= 1'b1;
                            st_reg <= H_IDLE;
                        end else if (bit_reg != CNT_ACK) begin
                            rx_reg <= {rx_reg[6:0], sda_s2_reg};
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            bit_reg <= bit_reg + 4'h1;
                        end else begin
                            bit_reg <= 4'h0;
                            st_reg <= H_STOP;
                            if (st_reg == H_RDATA) begin
                                rd_valid_reg <= 1'b1;
                                rd_data_reg <= rx_reg;
                                left_reg <= left_reg - 5'h01;
                                if (left_reg != 5'h01) begin
                                    st_reg <= H_RDATA;
                                end
                            end else if (sda_s2_reg) begin
                                nack_reg <= 1'b1;
                            end else if (st_reg == H_DEVW) begin
                                st_reg <= H_WADDR;
                                tx_reg <= addr_reg[7:0];
                            end else if (st_reg == H_WADDR) begin
                                st_reg <= (op_reg == OP_WRITE) ? H_WDATA : H_RESTART;
                                tx_reg <= wdata_reg;
                            end else if (st_reg == H_DEVR) begin
                                st_reg <= H_RDATA;
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule : ierwp_bus_master

// ---- ierwp_link_asserts.sv ----
// Purpose: Timing checks on the two-wire link, watched from the device side.
// Assumes: Signals sampled on the link clock; WP held steady across each transfer.
// Notes: Windows allow for the device's two-flop input synchronisers.
`timescale 1ns/1ps
module ierwp_link_asserts #(
    parameter int PROG_CYCLES = 2000
) (
    input wire logic LINK_CLK,
    input wire logic RST,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_oe,
    input wire logic BUSY,
    input wire logic WP
);
    logic scl_q_reg;
    logic sda_q_reg;
    logic [7:0] since_fall_reg;
    logic [3:0] since_stop_reg;
    logic [15:0] busy_cnt_reg;

    always_ff @(posedge LINK_CLK) begin
        scl_q_reg <= scl;
        sda_q_reg <= sda;
    end
    // Saturating fall and stop counts so a stale event never matches
    always_ff @(posedge LINK_CLK) begin
        if (RST) begin
            since_fall_reg <= 8'hff;
        end else if (scl_q_reg && !scl) begin
            since_fall_reg <= 8'h00;
        end else if (since_fall_reg != 8'hff) begin
            since_fall_reg <= since_fall_reg + 8'h01;
        end
    end
    always_ff @(posedge LINK_CLK) begin
        if (RST) begin
            since_stop_reg <= 4'hf;
        end else if (scl && scl_q_reg && sda && !sda_q_reg) begin
            since_stop_reg <= 4'h0;
        end else if (since_stop_reg != 4'hf) begin
            since_stop_reg <= since_stop_reg + 4'h1;
        end
    end
    always_ff @(posedge LINK_CLK) begin
        if (RST || !BUSY) begin
            busy_cnt_reg <= 16'h0000;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge LINK_CLK); endclocking
    default disable iff (RST);
    sequence s_stop;
        scl && $rose(sda);
    endsequence
    sequence s_scl_high;
        scl && $past(scl);
    endsequence

    a_busy_sda_free: assert property (BUSY |-> !sda_dev_oe)
        else $error("device drives data line while programming");
    a_dev_edge_time: assert property ($changed(sda_dev_oe) |-> since_fall_reg <= 8'h0a)
        else $error("device data change not tied to a clock fall");
    a_dev_hold_high: assert property (s_scl_high |-> $stable(sda_dev_oe))
        else $error("device data changed while clock high");
    a_reset_idle: assert property ($fell(RST) |-> !sda_dev_oe && !BUSY)
        else $error("device not idle after reset");
    a_stop_release: assert property (s_stop |=> !sda_dev_oe [*8])
        else $error("device drives after stop");
    a_busy_len: assert property ($fell(BUSY) |-> busy_cnt_reg inside {[PROG_CYCLES-1:PROG_CYCLES+1]})
        else $error("programming time wrong");
    a_busy_after_stop: assert property ($rose(BUSY) |-> since_stop_reg <= 4'h8)
        else $error("programming started without stop");
    a_wp_blocks_prog: assert property ($rose(BUSY) |-> !WP)
        else $error("programming started while protected");
endmodule : ierwp_link_asserts

// ---- i2c_eeprom_read_write_protect_tb.sv ----
// Purpose: Bench joining master end and device end on one link, self-checking.
// Assumes: Short quarter period so a poll lands inside programming time.
// Notes: Expected bytes follow from the writes made here and the erased start.
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module i2c_eeprom_read_write_protect_tb;
    import ierwp_pkg::*;
    localparam int PROG = 2000;
    logic CLK = 1'b0;
    logic LINK_CLK = 1'b0;
    logic RST = 1'b1;
    logic rst_dev = 1'b1;
    logic wp = 1'b0;
    logic cmd_valid = 1'b0;
    ierwp_op_e cmd_op = OP_WRITE;
    logic [1:0] cmd_cs = 2'h1;
    logic [ADDR_W-1:0] cmd_addr = 9'h000;
    logic [DATA_W-1:0] cmd_wdata = 8'h00;
    logic [4:0] cmd_len = 5'h00;
    logic cmd_ready, rd_valid, done, nack, busy;
    logic busy_seen = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] rq[$];
    int n_errors = 0;
    int tests_run = 0;

    ierwp_link_if link ();
    ierwp_eeprom_dev #(.PROG_CYCLES(PROG)) ierwp_eeprom_dev_i (
        .LINK_CLK(LINK_CLK), .RST(rst_dev), .LINK(link), .WP(wp),
        .CHIP_SELECT_PIN_LOW(1'b1), .CHIP_SELECT_PIN_HIGH(1'b0), .BUSY(busy));
    ierwp_bus_master #(.QUARTER_CYC(4)) ierwp_bus_master_i (
        .CLK(CLK), .RST(RST), .LINK(link), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
        .CMD_OP(cmd_op), .CMD_CS(cmd_cs), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
        .CMD_LEN(cmd_len), .RD_VALID(rd_valid), .RD_DATA(rd_data), .DONE(done), .NACK(nack));
    ierwp_link_asserts #(.PROG_CYCLES(PROG)) ierwp_link_asserts_i (
        .LINK_CLK(LINK_CLK), .RST(rst_dev), .scl(link.scl), .sda(link.sda),
        .sda_dev_oe(link.sda_dev_oe), .BUSY(busy), .WP(wp));

    always #25 CLK = ~CLK;
    // Odd offset keeps the link clock out of step with CLK
    initial begin
        #1.3;
        forever #3 LINK_CLK = ~LINK_CLK;
    end
    always @(posedge busy) busy_seen = 1'b1;

    task automatic stop_test();
        $display("Counts: tests_run %0d n_errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic cmd(input ierwp_op_e op, input logic [1:0] cs, input logic [8:0] a,
                       input logic [7:0] d, input logic [4:0] len);
        int k;
        rq.delete();
        busy_seen = 1'b0;
        @(posedge CLK);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_cs <= cs;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_len <= len;
        @(posedge CLK);
        cmd_valid <= 1'b0;
        for (k = 0; k < 5000; k++) begin
            @(posedge CLK);
            #1;
            if (rd_valid === 1'b1) rq.push_back(rd_data);
            if (done === 1'b1) break;
        end
        if (k == 5000) begin
            n_errors++;
            stop_test();
        end
    endtask : cmd

    task automatic rd(input ierwp_op_e op, input logic [8:0] a, input logic [4:0] n);
        // Length field is the byte count itself; zero also gives one byte
        cmd(op, 2'h1, a, 8'h00, n);
        `CHK(nack, 1'b0) // address acked
        `CHK(cmd_ready, 1'b1) // session over
        `CHK(rq.size(), int'(n)) // byte count
    endtask : rd

    task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic exp_nack, input logic exp_prog);
        cmd(OP_WRITE, 2'h1, a, d, 5'h00);
        `CHK(nack, exp_nack) // data ack
        // Busy rises a few link cycles after stop
        repeat (4) @(posedge CLK);
        `CHK(busy_seen, exp_prog) // programming started
    endtask : wr

    task automatic idle();
        int k;
        for (k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge CLK);
        if (k == 1000) begin
            n_errors++;
            stop_test();
        end
    endtask : idle

    initial begin
        repeat (3) @(posedge CLK);
        rst_dev <= 1'b0;
        @(posedge CLK);
        RST <= 1'b0;
        rd(OP_CUR_READ, 9'h000, 5'h02);
        `CHK(rq[0], ERASED_BYTE) // erased
        `CHK(rq[1], ERASED_BYTE) // next byte
        $display("test erased_read finished");
        wr(9'h010, 8'ha5, 1'b0, 1'b1); // plain write
        cmd(OP_CUR_READ, 2'h1, 9'h000, 8'h00, 5'h00);
        `CHK(nack, 1'b1) // ignored while busy
        idle();
        rd(OP_RAND_READ, 9'h010, 5'h01);
        `CHK(rq[0], 8'ha5) // random read
        $display("test write_poll_read finished");
        @(posedge CLK);
        wp <= 1'b1;
        wr(9'h010, 8'h3c, 1'b1, 1'b0); // refused
        @(posedge CLK);
        wp <= 1'b0;
        idle();
        rd(OP_RAND_READ, 9'h010, 5'h01);
        `CHK(rq[0], 8'ha5) // contents kept
        $display("test protect finished");
        wr(9'h1ff, 8'h5a, 1'b0, 1'b1); // upper bit
        idle();
        wr(9'h000, 8'h11, 1'b0, 1'b1); // low end
        idle();
        wr(9'h001, 8'h22, 1'b0, 1'b1); // low end
        idle();
        rd(OP_RAND_READ, 9'h1ff, 5'h02);
        `CHK(rq[0], 8'h5a) // last location
        `CHK(rq[1], 8'h11) // wrap to zero
        rd(OP_CUR_READ, 9'h000, 5'h01);
        `CHK(rq[0], 8'h22) // pointer advanced
        rd(OP_RAND_READ, 9'h0ff, 5'h01);
        `CHK(rq[0], ERASED_BYTE) // upper bit selects half
        $display("test wrap_read finished");
        cmd(OP_RAND_READ, 2'h2, 9'h010, 8'h00, 5'h00);
        `CHK(nack, 1'b1) // wrong select
        `CHK(rq.size(), 0) // no data
        $display("test wrong_select finished");
        stop_test();
    end
endmodule : i2c_eeprom_read_write_protect_tb
